// File: shared/acc_pkg.sv
// Package: address, field layout and reset values of the auxiliary cache control register
package acc_pkg;
  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [31:0] ACC_ADDR = 32'hE000EF9C;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ACC_SWT_BIT = 0;
  localparam int ACC_CHK_BIT = 1;
  localparam int ACC_FWT_BIT = 2;
  localparam logic [31:0] ACC_ZERO = 32'h00000000;
  // Check-disable reset values: checking on when built in, off when omitted
  localparam logic ACC_CHK_RST_ECC = 1'b0;
  localparam logic ACC_CHK_RST_NOECC = 1'b1;
  localparam logic ACC_BIT_RST = 1'b0;
endpackage : acc_pkg

// File: design/acc_regs.sv
// Auxiliary cache control register with its decoded cache policy outputs
//
// Operation
// (R1) Force write-through bit 2 makes data cache treat write-back regions as write-through.
// (R2) Without a data cache, force and shared write-through bits read as zero.
// (R3) Check-disable bit 1: zero enables checking in both caches, one disables.
// (R4) Writes to bit 1 ignored when both caches absent or checking not built.
// (R5) Bit 1 resets to 0 with checking built in, else 1.
// (R6) Shared write-through zero: shareable cacheable locations non-cacheable in both caches.
// (R7) Shared write-through one: data cache write-through, instruction cache non-cacheable.
// (R8) Shared write-through set makes every write globally visible.
// (R9) Software changes bit 1 only with caches off, then invalidates both.
// (R10) Bits 31 to 3 read as zero and ignore writes.
`timescale 1ns/1ps
module acc_regs #(
  parameter bit HAS_DCACHE = 1'b1,
  parameter bit HAS_ICACHE = 1'b1,
  parameter bit HAS_ECC = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Privileged register access
  input wire logic req_i,
  input wire logic wr_i,
  input wire logic priv_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o,
  output logic hit_o,
  // Cache policy
  output logic dc_force_wt_o,
  output logic dc_shared_wt_o,
  output logic ic_shared_nc_o,
  output logic dc_shared_nc_o,
  output logic writes_global_o,
  output logic ic_check_en_o,
  output logic dc_check_en_o
);
  import acc_pkg::*;

  // Reset value of the check bit, and whether writes to it may land at all
  localparam logic CHK_RST = HAS_ECC ? ACC_CHK_RST_ECC : ACC_CHK_RST_NOECC;
  localparam bit CHK_WR_OK = HAS_ECC && (HAS_DCACHE || HAS_ICACHE);

  // Stored bits and the registered read port
  logic fwt_q, fwt_d;
  logic chk_q, chk_d;
  logic swt_q, swt_d;
  logic [31:0] rdata_q, rdata_d;
  logic hit_q, hit_d;
  logic sel;
  logic [31:0] view;

  // ----------------------------------------------------------------
  // Register write and read
  // ----------------------------------------------------------------
  // Unprivileged accesses neither write nor read; hit_o stays low and rdata_o keeps its last value
  always_comb begin
    sel = req_i && priv_i && (addr_i == ACC_ADDR);
    view = ACC_ZERO; // R10
    view[ACC_FWT_BIT] = fwt_q;
    view[ACC_CHK_BIT] = chk_q;
    view[ACC_SWT_BIT] = swt_q;
    fwt_d = fwt_q;
    chk_d = chk_q;
    swt_d = swt_q;
    rdata_d = rdata_q;
    hit_d = sel;
    if (sel && wr_i) begin
      // Without a data cache both write-through bits stay at zero
      fwt_d = HAS_DCACHE ? wdata_i[ACC_FWT_BIT] : ACC_BIT_RST; // R2
      swt_d = HAS_DCACHE ? wdata_i[ACC_SWT_BIT] : ACC_BIT_RST; // R2
      if (CHK_WR_OK) begin
        chk_d = wdata_i[ACC_CHK_BIT]; // R4
      end
    end
    if (sel && !wr_i) begin
      rdata_d = view;
    end else if (sel) begin
      rdata_d = ACC_ZERO;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fwt_q <= ACC_BIT_RST;
      chk_q <= CHK_RST; // R5
      swt_q <= ACC_BIT_RST;
      rdata_q <= ACC_ZERO;
      hit_q <= 1'b0;
    end else begin
      fwt_q <= fwt_d;
      chk_q <= chk_d;
      swt_q <= swt_d;
      rdata_q <= rdata_d;
      hit_q <= hit_d;
    end
  end

  // ----------------------------------------------------------------
  // Policy decode
  // ----------------------------------------------------------------
  // Registered so each output comes straight from a flip-flop; lags bits by one edge.
  // Changing the check setting with live lines is unsafe; software keeps caches off. R9
  logic [6:0] pol_q, pol_d;
  always_comb begin
    pol_d[0] = fwt_q; // R1
    pol_d[1] = swt_q; // R7
    pol_d[2] = 1'b1; // R6 R7
    pol_d[3] = !swt_q; // R6
    pol_d[4] = swt_q; // R8
    pol_d[5] = HAS_ICACHE && !chk_q; // R3
    pol_d[6] = HAS_DCACHE && !chk_q; // R3
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pol_q <= 7'h00;
    end else begin
      pol_q <= pol_d;
    end
  end

  // Every output is a bare flip-flop, so the pins carry no decode glitches
  assign rdata_o = rdata_q;
  assign hit_o = hit_q;
  assign dc_force_wt_o = pol_q[0];
  assign dc_shared_wt_o = pol_q[1];
  assign ic_shared_nc_o = pol_q[2];
  assign dc_shared_nc_o = pol_q[3];
  assign writes_global_o = pol_q[4];
  assign ic_check_en_o = pol_q[5];
  assign dc_check_en_o = pol_q[6];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_fwt_follows;
    @(posedge clk_i) disable iff (!nrst_i)
      (sel && wr_i && HAS_DCACHE) |=> ##1 (dc_force_wt_o == $past(wdata_i[ACC_FWT_BIT], 2));
  endproperty
  a_fwt_follows: assert property (p_fwt_follows) else $error("force write-through wrong"); // R1

  property p_no_dc_zero;
    @(posedge clk_i) disable iff (!nrst_i)
      !HAS_DCACHE |-> (!fwt_q && !swt_q);
  endproperty
  a_no_dc_zero: assert property (p_no_dc_zero) else $error("bits set without data cache"); // R2

  // Look-back checks start only from edges that saw reset released; the release edge is vacuous
  property p_check_sense;
    @(posedge clk_i) disable iff (!nrst_i)
      nrst_i |=> (dc_check_en_o == (HAS_DCACHE && !$past(chk_q)));
  endproperty
  a_check_sense: assert property (p_check_sense) else $error("check enable sense wrong"); // R3

  property p_chk_wi;
    @(posedge clk_i) disable iff (!nrst_i)
      !CHK_WR_OK |=> $stable(chk_q);
  endproperty
  a_chk_wi: assert property (p_chk_wi) else $error("check bit changed though ignored"); // R4

  property p_chk_reset;
    @(posedge clk_i) $rose(nrst_i) |-> (chk_q == CHK_RST);
  endproperty
  a_chk_reset: assert property (p_chk_reset) else $error("check bit reset value wrong"); // R5

  property p_shared_modes;
    @(posedge clk_i) disable iff (!nrst_i)
      nrst_i |=> ((dc_shared_nc_o != dc_shared_wt_o) && ic_shared_nc_o);
  endproperty
  a_shared_modes: assert property (p_shared_modes) else $error("shared mode decode wrong"); // R6 R7

  property p_global;
    @(posedge clk_i) disable iff (!nrst_i)
      nrst_i |=> (writes_global_o == $past(swt_q));
  endproperty
  a_global: assert property (p_global) else $error("writes not global"); // R8

  property p_reserved;
    @(posedge clk_i) disable iff (!nrst_i)
      hit_o |-> (rdata_o[31:3] == 29'h0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero"); // R10

  // Decode outputs follow the stored bits one edge later, whatever they were
  property p_fwt_decode;
    @(posedge clk_i) disable iff (!nrst_i)
      nrst_i |=> (dc_force_wt_o == $past(fwt_q));
  endproperty
  a_fwt_decode: assert property (p_fwt_decode) else $error("force decode wrong"); // R1

  property p_ic_check_sense;
    @(posedge clk_i) disable iff (!nrst_i)
      nrst_i |=> (ic_check_en_o == (HAS_ICACHE && !$past(chk_q)));
  endproperty
  a_ic_check_sense: assert property (p_ic_check_sense) else $error("icache sense wrong"); // R3

  // A landed write sets the check bit to exactly what was written
  property p_chk_write;
    @(posedge clk_i) disable iff (!nrst_i)
      (sel && wr_i && CHK_WR_OK) |=> (chk_q == $past(wdata_i[ACC_CHK_BIT]));
  endproperty
  a_chk_write: assert property (p_chk_write) else $error("check bit write lost"); // R3 R4

  property p_swt_decode;
    @(posedge clk_i) disable iff (!nrst_i)
      nrst_i |=> ((dc_shared_wt_o == $past(swt_q)) && (dc_shared_nc_o == !$past(swt_q)));
  endproperty
  a_swt_decode: assert property (p_swt_decode) else $error("shared decode wrong"); // R6 R7

  // A read returns the stored bits as they stood at the access edge
  property p_read_view;
    @(posedge clk_i) disable iff (!nrst_i)
      (sel && !wr_i) |=> ((rdata_o[ACC_FWT_BIT] == $past(fwt_q))
        && (rdata_o[ACC_CHK_BIT] == $past(chk_q)) && (rdata_o[ACC_SWT_BIT] == $past(swt_q)));
  endproperty
  a_read_view: assert property (p_read_view) else $error("read data wrong"); // R2

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  // Writes, reads, shared write-through turning on, and both directions of the check bit

  c_write: cover property (@(posedge clk_i) disable iff (!nrst_i) sel && wr_i);
  c_read: cover property (@(posedge clk_i) disable iff (!nrst_i) sel && !wr_i);
  c_swt_on: cover property (@(posedge clk_i) disable iff (!nrst_i) $rose(writes_global_o));
  c_chk_off: cover property (@(posedge clk_i) disable iff (!nrst_i) $rose(chk_q));
  c_chk_on: cover property (@(posedge clk_i) disable iff (!nrst_i) $fell(chk_q));
endmodule // acc_regs

// File: bench/acc_regs_bench.sv
// Self-checking bench for the auxiliary cache control register
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module acc_regs_bench;
  import acc_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus, outputs and counters
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic req_i = 1'b0;
  logic wr_i = 1'b0;
  logic priv_i = 1'b0;
  logic [31:0] addr_i = ACC_ZERO;
  logic [31:0] wdata_i = ACC_ZERO;
  logic [31:0] rdata_o, rdata2;
  logic hit_o, dcf, dcs, icnc, dcnc, glob, icc, dcc;
  int fail_count = 0;
  int cmp_count = 0;
  // Full-featured core
  acc_regs i_acc_regs (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req_i), .wr_i(wr_i),
    .priv_i(priv_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .hit_o(hit_o),
    .dc_force_wt_o(dcf), .dc_shared_wt_o(dcs), .ic_shared_nc_o(icnc), .dc_shared_nc_o(dcnc),
    .writes_global_o(glob), .ic_check_en_o(icc), .dc_check_en_o(dcc));
  // Stripped core, no data cache and no checking, fed the same traffic
  acc_regs #(.HAS_DCACHE(1'b0), .HAS_ECC(1'b0)) i_acc_regs_lite (.clk_i(clk_i),
    .nrst_i(nrst_i), .req_i(req_i), .wr_i(wr_i), .priv_i(priv_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .rdata_o(rdata2), .hit_o(), .dc_force_wt_o(), .dc_shared_wt_o(),
    .ic_shared_nc_o(), .dc_shared_nc_o(), .writes_global_o(), .ic_check_en_o(),
    .dc_check_en_o());
  // Clock of 100 ns period
  always #50 clk_i = ~clk_i;
  // One access; returns just after the edge where the answer is registered
  task automatic access(input logic w, input logic p, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req_i <= 1'b1;
    wr_i <= w;
    priv_i <= p;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    req_i <= 1'b0;
    #1;
  endtask
  // Policy outputs lag the write by one more edge
  task automatic settle();
    @(posedge clk_i);
    #1;
  endtask
  task automatic t_reset();
    access(1'b0, 1'b1, ACC_ADDR, ACC_ZERO);
    `CHK(hit_o, 1'b1)
    `CHK(rdata_o, 32'h00000000)
    `CHK(rdata2, 32'h00000002)
    `CHK(icc, 1'b1)
  endtask
  task automatic t_write_all();
    // All ones sets bits 2 to 0 on the full core; the stripped core still reads back only its check bit
    access(1'b1, 1'b1, ACC_ADDR, 32'hFFFFFFFF);
    `CHK(hit_o, 1'b1)
    settle();
    `CHK(dcf, 1'b1)
    `CHK({dcs, icnc, dcnc}, 3'h6)
    `CHK(glob, 1'b1)
    `CHK({icc, dcc}, 2'h0)
    access(1'b0, 1'b1, ACC_ADDR, ACC_ZERO);
    `CHK(rdata_o, 32'h00000007)
    `CHK(rdata2, 32'h00000002)
  endtask
  task automatic t_write_zero();
    access(1'b1, 1'b1, ACC_ADDR, ACC_ZERO);
    settle();
    `CHK({dcs, icnc, dcnc, glob}, 4'h6)
    `CHK({dcf, icc, dcc}, 3'h3)
  endtask
  // Unprivileged and misaddressed writes must leave the register alone
  task automatic t_refuse();
    access(1'b1, 1'b0, ACC_ADDR, 32'h00000007);
    `CHK(hit_o, 1'b0)
    access(1'b1, 1'b1, ACC_ADDR + 32'h00000004, 32'h00000007);
    `CHK(hit_o, 1'b0)
    access(1'b0, 1'b1, ACC_ADDR, ACC_ZERO);
    `CHK(rdata_o, 32'h00000000)
  endtask
  // Reset in mid-run clears the outputs and brings back the reset value
  task automatic t_midreset();
    access(1'b1, 1'b1, ACC_ADDR, 32'h00000007);
    @(posedge clk_i);
    nrst_i <= 1'b0;
    #1;
    `CHK({dcf, dcs, glob, icc, dcc, hit_o}, 6'h00)
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_reset();
  endtask
  task automatic finish_test();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog, far beyond the few dozen cycles the tests need
  initial begin
    #200000;
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_write_all();
    t_write_zero();
    t_refuse();
    t_midreset();
    finish_test();
  end
endmodule // acc_regs_bench
